// *** core/caw_pkg.sv ***
// Constants for the counter array watchdog block
// Behaviour
// RL1 - Watchdog reset when low byte overflows while high byte equals compare high
// RL2 - Writing one to module 4 flag while watchdog enabled forces a reset
// RL3 - Timebase select and idle suspend frozen while watchdog enabled
// RL4 - Watchdog active when enable bit or lock bit is set
// RL5 - Lock holds watchdog on until reset; unlocked, clearing enable disables it
// RL6 - Reset: watchdog on, timebase clock/12, low byte and offset zero
// RL7 - Software sequence: disable, timebase, offset, idle, enable, lock, reload
// RL8 - Overflow flag set on 16-bit wrap, gated to interrupt, software clears
// RL9 - Run control bit 6 of control stops or starts the counter
// RL10 - Unused control bit 5 and mode bit 4 read zero, ignore writes
// RL11 - Five module flags set on match or capture, interrupt when enabled
// RL12 - Idle suspend bit 7 halts all array operation during processor idle; here only the timebase and counter halt, module flags still set
// RL13 - Enable bit 6 of mode dedicates module 4 to the watchdog
// RL14 - Timebase 000 clk/12, 001 clk/4, 010 timer 0, 011 falling count input
// RL15 - Timebase 100 clock, 101 external oscillator/8, 110 and 111 reserved
// RL16 - Overflow interrupt enable bit 0 of mode gates overflow interrupt
// RL17 - Mode register modifications ignored while watchdog enable bit is one; the enable and lock bits still take writes here
// RL18 - Compare high write while running loads high byte plus reload offset
// RL19 - Watchdog enabled forces counter running and blocks counter byte writes
// RL20 - One interrupt output: any control flag set with its enable set
package caw_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL  = 8'hD8;
   localparam logic [7:0] IDX_MODE     = 8'hD9;
   localparam logic [7:0] IDX_CNT_LO   = 8'hF9;
   localparam logic [7:0] IDX_CNT_HI   = 8'hFA;
   localparam logic [7:0] IDX_OFFSET   = 8'hFD;
   localparam logic [7:0] IDX_CMP_HI   = 8'hFE;
   localparam int         ADR_W        = 10;
   // Control register fields
   localparam int         CTL_OVF      = 7;
   localparam int         CTL_RUN      = 6;
   localparam int         CTL_M4       = 4;
   localparam int         NUM_MOD      = 5;
   // Mode register fields
   localparam int         MD_IDLE      = 7;
   localparam int         MD_WDE       = 6;
   localparam int         MD_LOCK      = 5;
   localparam int         MD_TB_LSB    = 1;
   localparam int         MD_OVF_IE    = 0;
   // Reset values
   localparam logic [7:0] RST_CONTROL  = 8'h00;
   localparam logic [7:0] RST_MODE     = 8'h40;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   // Timebase encodings and dividers
   localparam logic [2:0] TB_DIV12     = 3'h0;
   localparam logic [2:0] TB_DIV4      = 3'h1;
   localparam logic [2:0] TB_TIMER0    = 3'h2;
   localparam logic [2:0] TB_EXT_IN    = 3'h3;
   localparam logic [2:0] TB_SYSTEM_CLOCK    = 3'h4;
   localparam logic [2:0] TB_OSC_DIV8  = 3'h5;
   localparam logic [3:0] DIV12_LAST   = 4'hB;
   localparam logic [1:0] DIV4_LAST    = 2'h3;
   localparam logic [2:0] OSC_LAST     = 3'h7;
endpackage : caw_pkg

// *** core/caw_timebase.sv ***
// Counter clock source selection for the counter array
`timescale 1ns/1ns
`default_nettype none
module caw_timebase (
   input  wire logic       i_core_clk,
   input  wire logic       i_arst_n,
   input  wire logic [2:0] i_sel,
   input  wire logic       i_hold,
   input  wire logic       i_timer0_ovf,
   input  wire logic       i_ext_count,
   input  wire logic       i_ext_osc,
   output logic            o_tick
);
   logic [3:0] div12_q, div12_d;
   logic [1:0] div4_q,  div4_d;
   logic [2:0] osc_q,   osc_d;
   logic       ext_q,   ext_d;
   logic       oscp_q,  oscp_d;
   logic       osc_edge;

   always_comb begin
      div12_d  = div12_q;
      div4_d   = div4_q;
      osc_d    = osc_q;
      ext_d    = i_ext_count;
      oscp_d   = i_ext_osc;
      osc_edge = i_ext_osc & ~oscp_q;
      // Dividers freeze while suspended so no partial period is lost
      if (!i_hold) begin
         div12_d = (div12_q == caw_pkg::DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
         div4_d  = div4_q + 2'h1;
         if (osc_edge) begin
            osc_d = osc_q + 3'h1;
         end
      end
      o_tick = 1'b0;
      case (i_sel) // see RL14 see RL15
         caw_pkg::TB_DIV12:    o_tick = (div12_q == caw_pkg::DIV12_LAST);
         caw_pkg::TB_DIV4:     o_tick = (div4_q == caw_pkg::DIV4_LAST);
         caw_pkg::TB_TIMER0:   o_tick = i_timer0_ovf;
         caw_pkg::TB_EXT_IN:   o_tick = ext_q & ~i_ext_count;
         caw_pkg::TB_SYSTEM_CLOCK:   o_tick = 1'b1;
         caw_pkg::TB_OSC_DIV8: o_tick = osc_edge & (osc_q == caw_pkg::OSC_LAST);
         default:              o_tick = 1'b0;
      endcase
      if (i_hold) begin
         o_tick = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div12_q <= 4'h0;
         div4_q  <= 2'h0;
         osc_q   <= 3'h0;
         ext_q   <= 1'b1;
         oscp_q  <= 1'b0;
      end else begin
         div12_q <= div12_d;
         div4_q  <= div4_d;
         osc_q   <= osc_d;
         ext_q   <= ext_d;
         oscp_q  <= oscp_d;
      end
   end
endmodule : caw_timebase
`default_nettype wire

// *** core/caw_top.sv ***
// Counter array core with module 4 watchdog and Wishbone register access
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module caw_top (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_arst_n,
   // Wishbone classic slave
   input  wire logic                      i_wb_cyc,
   input  wire logic                      i_wb_stb,
   input  wire logic                      i_wb_we,
   input  wire logic [caw_pkg::ADR_W-1:0] i_wb_adr,
   input  wire logic [3:0]                i_wb_sel,
   input  wire logic [31:0]               i_wb_dat,
   output logic      [31:0]               o_wb_dat,
   output logic                           o_wb_ack,
   // Array environment
   input  wire logic                      i_cpu_idle,
   input  wire logic                      i_timer0_ovf,
   input  wire logic                      i_ext_count,
   input  wire logic                      i_ext_osc,
   input  wire logic [caw_pkg::NUM_MOD-1:0] i_module_event,
   input  wire logic [caw_pkg::NUM_MOD-1:0] i_module_irq_en,
   output logic                           o_irq,
   output logic                           o_wdt_reset
);
   // ------------------------------------------------------------
   // Address decode helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [caw_pkg::ADR_W-1:0] adr,
                                input logic [7:0]                idx);
      hit = (adr[caw_pkg::ADR_W-1:2] == idx);
   endfunction : hit

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic        ack_q,    ack_d;
   logic [31:0] rdat_q,   rdat_d;
   logic        irq_q,    irq_d;
   logic        wrst_q,   wrst_d;
   logic        ovf_q,    ovf_d;
   logic        run_q,    run_d;
   logic [4:0]  mflag_q,  mflag_d;
   logic        idle_q,   idle_d;
   logic        wde_q,    wde_d;
   logic        lock_q,   lock_d;
   logic [2:0]  tb_q,     tb_d;
   logic        ovfie_q,  ovfie_d;
   logic [15:0] cnt_q,    cnt_d;
   logic [7:0]  offs_q,   offs_d;
   logic [7:0]  cmph_q,   cmph_d;

   logic        wd_on;
   logic        wr_go;
   logic        hold;
   logic        tick;
   logic        inc;
   logic        lo_wrap;
   logic [7:0]  wbyte;
   logic [7:0]  ctl_rd;
   logic [7:0]  mode_rd;

   // ------------------------------------------------------------
   // Timebase
   // ------------------------------------------------------------
   caw_timebase u_timebase (
      .i_core_clk   (i_core_clk),
      .i_arst_n     (i_arst_n),
      .i_sel        (tb_q),
      .i_hold       (hold),
      .i_timer0_ovf (i_timer0_ovf),
      .i_ext_count  (i_ext_count),
      .i_ext_osc    (i_ext_osc),
      .o_tick       (tick)
   );

   // ------------------------------------------------------------
   // Shared combinational terms
   // ------------------------------------------------------------
   always_comb begin
      wd_on   = wde_q | lock_q; // see RL4 see RL13
      hold    = i_cpu_idle & idle_q; // see RL12
      inc     = tick & (run_q | wd_on); // see RL9 see RL19
      lo_wrap = inc & (cnt_q[7:0] == 8'hFF);
      wbyte   = i_wb_dat[7:0];
      // Writes commit on the edge where the master sees ack
      wr_go   = i_wb_cyc & i_wb_stb & i_wb_we & ack_q & i_wb_sel[0];
      ctl_rd  = {ovf_q, run_q, 1'b0, mflag_q}; // see RL10
      mode_rd = {idle_q, wde_q, lock_q, 1'b0, tb_q, ovfie_q}; // see RL10
   end

   // ------------------------------------------------------------
   // Bus slave: one wait state, unmapped reads return zero
   // ------------------------------------------------------------
   always_comb begin
      ack_d  = i_wb_cyc & i_wb_stb & ~ack_q;
      rdat_d = rdat_q;
      if (ack_d) begin
         rdat_d = 32'h0000_0000;
         if (hit(i_wb_adr, caw_pkg::IDX_CONTROL)) begin
            rdat_d[7:0] = ctl_rd;
         end else if (hit(i_wb_adr, caw_pkg::IDX_MODE)) begin
            rdat_d[7:0] = mode_rd;
         end else if (hit(i_wb_adr, caw_pkg::IDX_CNT_LO)) begin
            rdat_d[7:0] = cnt_q[7:0];
         end else if (hit(i_wb_adr, caw_pkg::IDX_CNT_HI)) begin
            rdat_d[7:0] = cnt_q[15:8];
         end else if (hit(i_wb_adr, caw_pkg::IDX_OFFSET)) begin
            rdat_d[7:0] = offs_q;
         end else if (hit(i_wb_adr, caw_pkg::IDX_CMP_HI)) begin
            rdat_d[7:0] = cmph_q;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // ------------------------------------------------------------
   // Control register and flags
   // ------------------------------------------------------------
   always_comb begin
      ovf_d   = ovf_q;
      run_d   = run_q;
      mflag_d = mflag_q;
      if (wr_go && hit(i_wb_adr, caw_pkg::IDX_CONTROL)) begin
         ovf_d   = wbyte[caw_pkg::CTL_OVF];
         run_d   = wbyte[caw_pkg::CTL_RUN]; // see RL9
         mflag_d = wbyte[caw_pkg::NUM_MOD-1:0];
      end
      // Hardware set beats a same-cycle software clear
      if (inc && cnt_q == 16'hFFFF) begin
         ovf_d = 1'b1; // see RL8
      end
      for (int m = 0; m < caw_pkg::NUM_MOD; m++) begin
         // Module 4 events belong to the watchdog while it runs
         if (i_module_event[m] && !(m == caw_pkg::CTL_M4 && wd_on)) begin
            mflag_d[m] = 1'b1; // see RL11
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ovf_q   <= caw_pkg::RST_CONTROL[caw_pkg::CTL_OVF];
         run_q   <= caw_pkg::RST_CONTROL[caw_pkg::CTL_RUN];
         mflag_q <= caw_pkg::RST_CONTROL[caw_pkg::NUM_MOD-1:0];
      end else begin
         ovf_q   <= ovf_d;
         run_q   <= run_d;
         mflag_q <= mflag_d;
      end
   end

   // ------------------------------------------------------------
   // Mode register
   // ------------------------------------------------------------
   always_comb begin
      idle_d  = idle_q;
      wde_d   = wde_q;
      lock_d  = lock_q;
      tb_d    = tb_q;
      ovfie_d = ovfie_q;
      if (wr_go && hit(i_wb_adr, caw_pkg::IDX_MODE)) begin
         // Only the enable and lock bits stay writable while running
         if (!wd_on) begin // see RL17 see RL3
            idle_d  = wbyte[caw_pkg::MD_IDLE];
            tb_d    = wbyte[caw_pkg::MD_TB_LSB +: 3];
            ovfie_d = wbyte[caw_pkg::MD_OVF_IE];
         end
         wde_d  = wbyte[caw_pkg::MD_WDE]; // see RL5
         // Lock only sets; it clears on system reset alone
         lock_d = lock_q | wbyte[caw_pkg::MD_LOCK]; // see RL5
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         idle_q  <= caw_pkg::RST_MODE[caw_pkg::MD_IDLE];
         wde_q   <= caw_pkg::RST_MODE[caw_pkg::MD_WDE]; // see RL6
         lock_q  <= caw_pkg::RST_MODE[caw_pkg::MD_LOCK];
         tb_q    <= caw_pkg::RST_MODE[caw_pkg::MD_TB_LSB +: 3];
         ovfie_q <= caw_pkg::RST_MODE[caw_pkg::MD_OVF_IE];
      end else begin
         idle_q  <= idle_d;
         wde_q   <= wde_d;
         lock_q  <= lock_d;
         tb_q    <= tb_d;
         ovfie_q <= ovfie_d;
      end
   end

   // ------------------------------------------------------------
   // Counter, reload offset and watchdog compare
   // ------------------------------------------------------------
   always_comb begin
      cnt_d  = cnt_q;
      offs_d = offs_q;
      cmph_d = cmph_q;
      if (inc) begin
         cnt_d = cnt_q + 16'h0001;
      end
      if (wr_go && !wd_on) begin // see RL19
         if (hit(i_wb_adr, caw_pkg::IDX_CNT_LO)) begin
            cnt_d[7:0] = wbyte;
         end else if (hit(i_wb_adr, caw_pkg::IDX_CNT_HI)) begin
            cnt_d[15:8] = wbyte;
         end
      end
      if (wr_go && hit(i_wb_adr, caw_pkg::IDX_OFFSET)) begin
         offs_d = wbyte;
      end
      if (wr_go && hit(i_wb_adr, caw_pkg::IDX_CMP_HI)) begin
         // Any value reloads while the watchdog runs: deadline moves to high byte plus offset
         cmph_d = wd_on ? cnt_q[15:8] + offs_q : wbyte; // see RL18
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q  <= {caw_pkg::RST_BYTE, caw_pkg::RST_BYTE}; // see RL6
         offs_q <= caw_pkg::RST_BYTE;
         cmph_q <= caw_pkg::RST_BYTE;
      end else begin
         cnt_q  <= cnt_d;
         offs_q <= offs_d;
         cmph_q <= cmph_d;
      end
   end

   // ------------------------------------------------------------
   // Watchdog reset and interrupt outputs
   // ------------------------------------------------------------
   always_comb begin
      wrst_d = 1'b0;
      if (wd_on && lo_wrap && cnt_q[15:8] == cmph_q) begin
         wrst_d = 1'b1; // see RL1
      end
      if (wd_on && wr_go && hit(i_wb_adr, caw_pkg::IDX_CONTROL)
          && wbyte[caw_pkg::CTL_M4]) begin
         wrst_d = 1'b1; // see RL2
      end
      // Level request; stays while any enabled flag stays set
      irq_d = (ovf_q & ovfie_q) | (|(mflag_q & i_module_irq_en)); // see RL16 see RL20
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wrst_q <= 1'b0;
         irq_q  <= 1'b0;
      end else begin
         wrst_q <= wrst_d;
         irq_q  <= irq_d;
      end
   end

   assign o_wb_ack    = ack_q;
   assign o_wb_dat    = rdat_q;
   assign o_irq       = irq_q;
   assign o_wdt_reset = wrst_q;
endmodule : caw_top
`default_nettype wire

// *** tb/caw_top_sva.sv ***
// Port-level checker for the counter array watchdog block
`timescale 1ns/1ns
`default_nettype none
module caw_top_sva (
   input wire logic                        i_core_clk,
   input wire logic                        i_arst_n,
   input wire logic                        i_wb_cyc,
   input wire logic                        i_wb_stb,
   input wire logic                        i_wb_we,
   input wire logic [caw_pkg::ADR_W-1:0]   i_wb_adr,
   input wire logic [3:0]                  i_wb_sel,
   input wire logic [31:0]                 i_wb_dat,
   input wire logic [31:0]                 o_wb_dat,
   input wire logic                        o_wb_ack,
   input wire logic                        i_cpu_idle,
   input wire logic                        i_timer0_ovf,
   input wire logic                        i_ext_count,
   input wire logic                        i_ext_osc,
   input wire logic [caw_pkg::NUM_MOD-1:0] i_module_event,
   input wire logic [caw_pkg::NUM_MOD-1:0] i_module_irq_en,
   input wire logic                        o_irq,
   input wire logic                        o_wdt_reset
);
   logic [11:0] since_q;
   logic [11:0] since_d;
   logic        lock_q;
   logic        lock_d;
   logic        rd_ack;
   logic        mapped;
   logic [7:0]  idx;
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   always_comb begin
      idx     = i_wb_adr[9:2];
      rd_ack  = o_wb_ack && !i_wb_we;
      mapped  = idx == caw_pkg::IDX_CONTROL || idx == caw_pkg::IDX_MODE ||
                idx == caw_pkg::IDX_CNT_LO || idx == caw_pkg::IDX_CNT_HI ||
                idx == caw_pkg::IDX_OFFSET || idx == caw_pkg::IDX_CMP_HI;
      // Saturates so the quiet window is only the one after release
      since_d = (since_q == 12'hFFF) ? since_q : since_q + 12'h001;
      lock_d  = lock_q | (rd_ack && idx == caw_pkg::IDX_MODE && o_wb_dat[5]);
   end
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         since_q <= 12'h000;
         lock_q  <= 1'b0;
      end else begin
         since_q <= since_d;
         lock_q  <= lock_d;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);
   ack_one_cycle_a : assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   ack_answer_a : assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("request not answered in one cycle");
   ack_idle_a : assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
      else $error("ack without request");
   rd_upper_zero_a : assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   unmapped_read_a : assert property (rd_ack && !mapped |-> o_wb_dat == 32'h00000000)
      else $error("unmapped read not zero");
   unused_bits_a : assert property (
      rd_ack && (idx == caw_pkg::IDX_CONTROL || idx == caw_pkg::IDX_MODE) |->
      !((idx == caw_pkg::IDX_CONTROL) ? o_wb_dat[5] : o_wb_dat[4]))
      else $error("unused bit reads one");
   early_quiet_a : assert property (since_q < 12'hBB8 |-> !o_wdt_reset)
      else $error("watchdog reset before default timeout");
   lock_sticky_a : assert property (
      rd_ack && idx == caw_pkg::IDX_MODE && lock_q |-> o_wb_dat[5])
      else $error("lock bit cleared without reset");
endmodule : caw_top_sva
bind caw_top caw_top_sva u_sva (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
   .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
   .i_cpu_idle(i_cpu_idle), .i_timer0_ovf(i_timer0_ovf), .i_ext_count(i_ext_count),
   .i_ext_osc(i_ext_osc), .i_module_event(i_module_event),
   .i_module_irq_en(i_module_irq_en), .o_irq(o_irq), .o_wdt_reset(o_wdt_reset));
`default_nettype wire

// *** tb/tb_caw_top.sv ***
// Self-checking testbench for the counter array watchdog block
`timescale 1ns/1ns
`default_nettype none
module tb_caw_top;
   typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} caw_row_t;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wdat = 32'h00000000;
   logic [4:0]  ev = 5'h00;
   logic [4:0]  irq_en = 5'h00;
   logic        idle = 1'b0;
   logic        t0 = 1'b0;
   logic        ext = 1'b1;
   logic        osc = 1'b0;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic        wdt;
   logic [7:0]  r;
   logic [7:0]  a;
   int          fails = 0;
   int          checked = 0;
   int          ncyc = 0;
   int          first = 0;
   int          pulses = 0;
   int          p;
   int          n;
   caw_row_t    rows [8] = '{
      '{caw_pkg::IDX_MODE, 8'h9B, 8'h00}, '{caw_pkg::IDX_MODE, 8'h9B, 8'h8B},
      '{caw_pkg::IDX_MODE, 8'h00, 8'h00}, '{caw_pkg::IDX_CONTROL, 8'h20, 8'h00},
      '{caw_pkg::IDX_OFFSET, 8'h5A, 8'h5A}, '{caw_pkg::IDX_CMP_HI, 8'h33, 8'h33},
      '{caw_pkg::IDX_CNT_LO, 8'h12, 8'h12}, '{caw_pkg::IDX_CNT_HI, 8'hFF, 8'hFF}};
   caw_top dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_cpu_idle(idle), .i_timer0_ovf(t0), .i_ext_count(ext),
      .i_ext_osc(osc), .i_module_event(ev), .i_module_irq_en(irq_en), .o_irq(irq),
      .o_wdt_reset(wdt));
   always #5 clk = ~clk;
   // Cycle count since release and watchdog pulse monitor
   always @(posedge clk) begin
      if (arst_n) ncyc <= ncyc + 1;
      if (wdt === 1'b1) pulses <= pulses + 1;
      if (wdt === 1'b1 && first == 0) first <= ncyc;
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] rd);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h000000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      wb(1'b0, caw_pkg::IDX_CONTROL, 8'h00, r); chk(r, caw_pkg::RST_CONTROL);
      wb(1'b0, caw_pkg::IDX_MODE, 8'h00, r); chk(r, caw_pkg::RST_MODE);
      wb(1'b0, caw_pkg::IDX_OFFSET, 8'h00, r); chk(r, caw_pkg::RST_BYTE);
      wb(1'b0, 8'h10, 8'h00, r); chk(r, 8'h00);
      n = 0;
      while (pulses == 0 && n < 4000) begin @(posedge clk); n++; end
      chk({31'h0, first >= 3060 && first <= 3090}, 1);
      $display("test default timeout done");
      foreach (rows[i]) begin
         wb(1'b1, rows[i].idx, rows[i].wd, r);
         wb(1'b0, rows[i].idx, 8'h00, r);
         chk(r, rows[i].ex);
      end
      $display("test register table done");
      wb(1'b1, caw_pkg::IDX_MODE, 8'h09, r);
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h40, r);
      repeat (300) @(posedge clk);
      wb(1'b0, caw_pkg::IDX_CONTROL, 8'h00, r); chk(r, 8'hC0);
      chk(irq, 1'b1);
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h40, r);
      wb(1'b0, caw_pkg::IDX_CONTROL, 8'h00, r); chk(r, 8'h40);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h00, r);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, a);
      repeat (20) @(posedge clk);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk(r, a);
      $display("test overflow and run done");
      ev <= 5'h1F;
      @(posedge clk);
      ev <= 5'h00;
      wb(1'b0, caw_pkg::IDX_CONTROL, 8'h00, r); chk(r, 8'h1F);
      chk(irq, 1'b0);
      irq_en <= 5'h04;
      repeat (3) @(posedge clk);
      chk(irq, 1'b1);
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h00, r);
      wb(1'b0, caw_pkg::IDX_CONTROL, 8'h00, r); chk(r, 8'h00);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
      irq_en <= 5'h00;
      $display("test module flags done");
      wb(1'b1, caw_pkg::IDX_MODE, 8'h48, r);
      wb(1'b1, caw_pkg::IDX_MODE, 8'hCB, r);
      wb(1'b0, caw_pkg::IDX_MODE, 8'h00, r); chk(r, 8'h48);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, a);
      repeat (20) @(posedge clk);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk({31'h0, r !== a}, 1);
      p = pulses;
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h10, r);
      repeat (3) @(posedge clk);
      chk(pulses, p + 1);
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h00, r);
      wb(1'b1, caw_pkg::IDX_OFFSET, 8'h01, r);
      p = pulses;
      wb(1'b1, caw_pkg::IDX_CMP_HI, 8'hA5, r);
      n = 0;
      while (pulses == p && n < 600) begin @(posedge clk); n++; end
      chk({31'h0, pulses == p + 1 && n >= 250}, 1);
      $display("test watchdog reload done");
      wb(1'b1, caw_pkg::IDX_MODE, 8'h68, r);
      wb(1'b1, caw_pkg::IDX_MODE, 8'h00, r);
      wb(1'b0, caw_pkg::IDX_MODE, 8'h00, r); chk(r, 8'h28);
      p = pulses;
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h10, r);
      repeat (3) @(posedge clk);
      chk(pulses, p + 1);
      $display("test lock done");
      // Mid-run reset must drop the lock and restore defaults
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      wb(1'b0, caw_pkg::IDX_MODE, 8'h00, r); chk(r, caw_pkg::RST_MODE);
      wb(1'b0, caw_pkg::IDX_CONTROL, 8'h00, r); chk(r, caw_pkg::RST_CONTROL);
      wb(1'b1, caw_pkg::IDX_MODE, 8'h00, r);
      wb(1'b1, caw_pkg::IDX_MODE, 8'h88, r);
      wb(1'b1, caw_pkg::IDX_CONTROL, 8'h40, r);
      idle <= 1'b1;
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, a);
      repeat (20) @(posedge clk);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk(r, a);
      idle <= 1'b0;
      repeat (20) @(posedge clk);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk({31'h0, r !== a}, 1);
      $display("test reset and idle done");
      wb(1'b1, caw_pkg::IDX_MODE, 8'h04, r);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, a);
      repeat (5) begin
         t0 <= 1'b1;
         @(posedge clk);
         t0 <= 1'b0;
         @(posedge clk);
      end
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk(r, 8'(a + 8'h05));
      wb(1'b1, caw_pkg::IDX_MODE, 8'h06, r);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, a);
      // Count input kept at a quarter of the clock rate
      repeat (3) begin
         ext <= 1'b0;
         repeat (2) @(posedge clk);
         ext <= 1'b1;
         repeat (2) @(posedge clk);
      end
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk(r, 8'(a + 8'h03));
      wb(1'b1, caw_pkg::IDX_MODE, 8'h0A, r);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, a);
      repeat (16) begin
         osc <= 1'b1;
         @(posedge clk);
         osc <= 1'b0;
         @(posedge clk);
      end
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk(r, 8'(a + 8'h02));
      wb(1'b1, caw_pkg::IDX_MODE, 8'h0C, r);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, a);
      repeat (20) @(posedge clk);
      wb(1'b0, caw_pkg::IDX_CNT_LO, 8'h00, r); chk(r, a);
      $display("test timebase sources done");
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict();
   end
endmodule : tb_caw_top
`default_nettype wire
